/* File: design/safety_pkg.sv */
package safety_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned CNT_W = 12;
  localparam int unsigned RST_MIN_MS = 250;
  localparam int unsigned RST_MAX_MS = 2000;
  localparam int unsigned SKEW_MAX_MS = 3000;
  localparam int unsigned SSI_SKEW_MS = 3000;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned SEC_MS = 1000;
  localparam logic [CNT_W-1:0] RST_MIN_TICKS = CNT_W'((RST_MIN_MS * 1000 + TICK_US - 1) / TICK_US);
  localparam logic [CNT_W-1:0] RST_MAX_TICKS = CNT_W'((RST_MAX_MS * 1000) / TICK_US);
  localparam logic [CNT_W-1:0] SKEW_MAX_TICKS = CNT_W'((SKEW_MAX_MS * 1000) / TICK_US);
  localparam logic [CNT_W-1:0] SSI_SKEW_TICKS = CNT_W'((SSI_SKEW_MS * 1000) / TICK_US);
  localparam logic [CNT_W-1:0] FLASH_TICKS = CNT_W'((FLASH_MS * 1000) / TICK_US);
  localparam logic [CNT_W-1:0] SEC_TICKS = CNT_W'((SEC_MS * 1000) / TICK_US);
  localparam logic [5:0] BD_SHORT_S = 6'h1e;
  localparam logic [5:0] BD_LONG_S = 6'h3c;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned CTRL_MANUAL_BIT = 0;
  localparam int unsigned CTRL_ONE_WAY_BIT = 1;
  localparam int unsigned CTRL_PERMIT_BIT = 2;
  localparam int unsigned CTRL_BD_LSB = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h01;
  localparam logic [1:0] BD_NONE = 2'h0;
  localparam logic [1:0] BD_30 = 2'h1;
  localparam logic [1:0] BD_60 = 2'h2;
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_STOP = 0;
  localparam int unsigned IRQ_LOCK = 1;
  localparam int unsigned IRQ_MUTE_ON = 2;
  localparam int unsigned IRQ_MUTE_OFF = 3;
  localparam int unsigned IRQ_RESET_OK = 4;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

  typedef enum logic [1:0] {ST_WAIT, ST_RUN, ST_MUTE, ST_LOCKOUT} state_t;

endpackage

/* File: design/sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule
`default_nettype wire

/* File: design/safety_muting_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module safety_muting_controller #(
  parameter int unsigned TICK_CYCLES_P = safety_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [1:0] primary_safeguard_input,
  input wire logic [1:0] supplemental_stop_input,
  input wire logic reset_switch,
  input wire logic first_pair_sensor_a,
  input wire logic first_pair_sensor_b,
  input wire logic second_pair_sensor_a,
  input wire logic second_pair_sensor_b,
  input wire logic mute_permit_input,
  output logic [1:0] safety_switching_output,
  output logic green_led,
  output logic yellow_led,
  output logic red_led,
  output logic mute_lamp,
  output logic [1:0] primary_chan_led,
  output logic [1:0] supplemental_chan_led,
  output logic disp_dash,
  output logic [3:0] disp_tens,
  output logic [3:0] disp_ones
);
  import safety_pkg::*;

  // ==========================================================================
  // Input synchronisers
  logic [1:0] psi_s, ssi_s;
  logic rsw_s, s1a_s, s1b_s, s2a_s, s2b_s, permit_s;

  sync2 #(.W(10)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({mute_permit_input, second_pair_sensor_b, second_pair_sensor_a, first_pair_sensor_b,
        first_pair_sensor_a, reset_switch, supplemental_stop_input, primary_safeguard_input}),
    .q({permit_s, s2b_s, s2a_s, s1b_s, s1a_s, rsw_s, ssi_s, psi_s})
  );

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    return (v == '1) ? v : v + 12'h001;
  endfunction

  // ==========================================================================
  // Registers
  state_t state_ff, nxt_state;
  logic [31:0] tick_ff, nxt_tick;
  logic [CNT_W-1:0] flash_cnt_ff, nxt_flash_cnt, hold_ff, nxt_hold, ssi_skew_ff, nxt_ssi_skew;
  logic [CNT_W-1:0] sec_ms_ff, nxt_sec_ms;
  logic [1:0][CNT_W-1:0] skew_ff, nxt_skew;
  logic [1:0] both_d_ff, nxt_both_d, pair_bad_ff, nxt_pair_bad;
  logic flash_ff, nxt_flash, rsw_d_ff, press_ok_ff, nxt_press_ok, pwrup_ff, nxt_pwrup;
  logic open_seen_ff, nxt_open_seen;
  logic [5:0] secs_ff, nxt_secs;
  logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat, irq_mask_ff, nxt_irq_mask, events;
  logic [31:0] prdata_ff, nxt_prdata;
  logic err_ff, nxt_err, irq_ff, nxt_irq;
  logic [1:0] ssout_ff, nxt_ssout, pled_ff, sled_ff;
  logic green_ff, yellow_ff, red_ff, mute_ff, dash_ff, nxt_green, nxt_yellow, nxt_red, nxt_mute, nxt_dash;
  logic [3:0] tens_ff, ones_ff, nxt_tens, nxt_ones;

  // ==========================================================================
  // Decoded conditions
  logic ms_tick, psi_clear, ssi_clear, guards_clear, any_sensor, bypass, timed, bd_expire, sec_tick;
  logic reset_accept, ssi_fault, mute_req, mute_ok, cfg_manual, cfg_one_way, cfg_permit;
  logic [1:0] pa, pb, pair_start, cfg_bd;

  always_comb begin
    cfg_manual = ctrl_ff[CTRL_MANUAL_BIT];
    cfg_one_way = ctrl_ff[CTRL_ONE_WAY_BIT];
    cfg_permit = ctrl_ff[CTRL_PERMIT_BIT];
    cfg_bd = ctrl_ff[CTRL_BD_LSB +: 2];
    ms_tick = (tick_ff == 32'(TICK_CYCLES_P - 1));
    psi_clear = &psi_s;
    ssi_clear = &ssi_s;
    guards_clear = psi_clear && ssi_clear;
    pa = {s2a_s, s1a_s};
    pb = {s2b_s, s1b_s};
    any_sensor = |{pa, pb};
    bypass = (state_ff == ST_MUTE) && !psi_clear;
    timed = (cfg_bd == BD_30) || (cfg_bd == BD_60);
    bd_expire = bypass && timed && (secs_ff == 6'h00);
    sec_tick = ms_tick && (sec_ms_ff == SEC_TICKS - 12'h001);
    ssi_fault = (ssi_skew_ff >= SSI_SKEW_TICKS);
    reset_accept = !rsw_s && rsw_d_ff && press_ok_ff && guards_clear &&
                   (hold_ff >= RST_MIN_TICKS) && (hold_ff <= RST_MAX_TICKS);
    for (int p = 0; p < 2; p++) begin
      pair_start[p] = pa[p] && pb[p] && !both_d_ff[p] && !pair_bad_ff[p] &&
                      (skew_ff[p] <= SKEW_MAX_TICKS);
    end
    mute_req = cfg_one_way ? (pair_start[0] && !pa[1] && !pb[1]) : (|pair_start);
    mute_ok = mute_req && (!cfg_permit || permit_s);
  end

  // ==========================================================================
  // Timers, switch and sensor tracking
  always_comb begin
    nxt_tick = ms_tick ? 32'h0 : tick_ff + 32'h1;
    nxt_flash_cnt = flash_cnt_ff;
    nxt_flash = flash_ff;
    if (ms_tick) begin
      nxt_flash_cnt = flash_cnt_ff + 12'h001;
      if (flash_cnt_ff == FLASH_TICKS - 12'h001) begin
        nxt_flash_cnt = '0;
        nxt_flash = !flash_ff;
      end
    end
    nxt_hold = rsw_s ? (ms_tick ? sat_inc(hold_ff) : hold_ff) : '0;
    nxt_press_ok = press_ok_ff;
    if (rsw_s && !rsw_d_ff) begin
      nxt_press_ok = guards_clear;
    end else if (rsw_s && !guards_clear) begin
      nxt_press_ok = 1'b0;
    end
    nxt_ssi_skew = (ssi_s[0] != ssi_s[1]) ? (ms_tick ? sat_inc(ssi_skew_ff) : ssi_skew_ff) : '0;
    for (int p = 0; p < 2; p++) begin
      nxt_both_d[p] = pa[p] && pb[p];
      nxt_skew[p] = (pa[p] || pb[p]) ? ((ms_tick && !(pa[p] && pb[p])) ? sat_inc(skew_ff[p]) : skew_ff[p]) : '0;
      nxt_pair_bad[p] = (pa[p] || pb[p]) && (pair_bad_ff[p] || (skew_ff[p] > SKEW_MAX_TICKS));
    end
    nxt_sec_ms = bypass ? (ms_tick ? (sec_tick ? '0 : sec_ms_ff + 12'h001) : sec_ms_ff) : '0;
    nxt_secs = (cfg_bd == BD_60) ? BD_LONG_S : BD_SHORT_S;
    if (bypass) begin
      nxt_secs = (sec_tick && secs_ff != 6'h00) ? secs_ff - 6'h01 : secs_ff;
    end
    nxt_open_seen = (state_ff == ST_LOCKOUT) && (open_seen_ff || (ssi_s == 2'b00));
  end

  // ==========================================================================
  // Main state machine
  always_comb begin
    nxt_state = state_ff;
    nxt_pwrup = pwrup_ff;
    case (state_ff)
      ST_WAIT: begin
        if (ssi_fault) begin
          nxt_state = ST_LOCKOUT;
        end else if ((cfg_manual || pwrup_ff) ? reset_accept : guards_clear) begin
          nxt_state = ST_RUN;
          nxt_pwrup = 1'b0;
        end
      end
      ST_RUN: begin
        if (ssi_fault) begin
          nxt_state = ST_LOCKOUT;
        end else if (!guards_clear) begin
          nxt_state = ST_WAIT;
        end else if (mute_ok) begin
          nxt_state = ST_MUTE;
        end
      end
      ST_MUTE: begin
        if (ssi_fault) begin
          nxt_state = ST_LOCKOUT;
        end else if (!ssi_clear || bd_expire) begin
          nxt_state = ST_WAIT;
        end else if (!any_sensor) begin
          nxt_state = psi_clear ? ST_RUN : ST_WAIT;
        end
      end
      ST_LOCKOUT: begin
        if (open_seen_ff && ssi_clear) begin
          nxt_state = ST_WAIT;
        end
      end
      default: begin
        nxt_state = ST_WAIT;
      end
    endcase
  end

  // ==========================================================================
  // Outputs and indicators
  always_comb begin
    logic [5:0] tens;
    tens = nxt_secs / 6'h0a;
    nxt_ssout = ((nxt_state == ST_RUN) || (nxt_state == ST_MUTE)) ? 2'b11 : 2'b00;
    nxt_green = nxt_ssout[0];
    nxt_yellow = (nxt_state == ST_WAIT) && (cfg_manual || nxt_pwrup) && nxt_flash;
    nxt_red = (nxt_state == ST_LOCKOUT) && nxt_flash;
    nxt_mute = (nxt_state == ST_MUTE);
    nxt_dash = (nxt_state == ST_MUTE) && !psi_clear && !timed && nxt_flash;
    nxt_tens = '0;
    nxt_ones = '0;
    if ((nxt_state == ST_MUTE) && !psi_clear && timed) begin
      nxt_tens = tens[3:0];
      nxt_ones = 4'(nxt_secs - 6'(tens * 6'h0a));
    end
  end

  // ==========================================================================
  // APB slave, control and interrupt registers
  logic setup, wr_en;

  always_comb begin
    setup = psel && !penable;
    wr_en = psel && penable && pwrite;
    events = '0;
    events[IRQ_STOP] = (nxt_state == ST_WAIT) && ((state_ff == ST_RUN) || (state_ff == ST_MUTE));
    events[IRQ_LOCK] = (nxt_state == ST_LOCKOUT) && (state_ff != ST_LOCKOUT);
    events[IRQ_MUTE_ON] = (nxt_state == ST_MUTE) && (state_ff != ST_MUTE);
    events[IRQ_MUTE_OFF] = (state_ff == ST_MUTE) && (nxt_state != ST_MUTE);
    events[IRQ_RESET_OK] = (state_ff == ST_WAIT) && (nxt_state == ST_RUN);
    nxt_ctrl = ctrl_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_irq_stat = irq_stat_ff;
    if (wr_en && paddr == ADDR_CTRL) begin
      nxt_ctrl = pwdata[CTRL_W-1:0];
    end
    if (wr_en && paddr == ADDR_IRQ_MASK) begin
      nxt_irq_mask = pwdata[IRQ_W-1:0];
    end
    if (wr_en && paddr == ADDR_IRQ_STAT) begin
      nxt_irq_stat = irq_stat_ff & ~pwdata[IRQ_W-1:0];
    end
    nxt_irq_stat = nxt_irq_stat | events;
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
    nxt_prdata = prdata_ff;
    nxt_err = err_ff;
    if (setup) begin
      nxt_err = 1'b0;
      nxt_prdata = '0;
      case (paddr)
        ADDR_CTRL: nxt_prdata = 32'(ctrl_ff);
        ADDR_STATUS: nxt_prdata = {16'h0000, 2'b00, secs_ff, pwrup_ff, bypass, mute_ff, green_ff,
                                   ssout_ff, state_ff};
        ADDR_IRQ_STAT: nxt_prdata = 32'(irq_stat_ff);
        ADDR_IRQ_MASK: nxt_prdata = 32'(irq_mask_ff);
        default: nxt_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_WAIT;
      tick_ff <= '0;
      flash_cnt_ff <= '0;
      flash_ff <= 1'b0;
      hold_ff <= '0;
      rsw_d_ff <= 1'b0;
      press_ok_ff <= 1'b0;
      pwrup_ff <= 1'b1;
      ssi_skew_ff <= '0;
      skew_ff <= '0;
      both_d_ff <= '0;
      pair_bad_ff <= '0;
      sec_ms_ff <= '0;
      secs_ff <= BD_SHORT_S;
      open_seen_ff <= 1'b0;
      ctrl_ff <= CTRL_RESET;
      irq_stat_ff <= IRQ_RESET;
      irq_mask_ff <= IRQ_RESET;
      irq_ff <= 1'b0;
      prdata_ff <= '0;
      err_ff <= 1'b0;
      ssout_ff <= '0;
      green_ff <= 1'b0;
      yellow_ff <= 1'b0;
      red_ff <= 1'b0;
      mute_ff <= 1'b0;
      dash_ff <= 1'b0;
      tens_ff <= '0;
      ones_ff <= '0;
      pled_ff <= '0;
      sled_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      tick_ff <= nxt_tick;
      flash_cnt_ff <= nxt_flash_cnt;
      flash_ff <= nxt_flash;
      hold_ff <= nxt_hold;
      rsw_d_ff <= rsw_s;
      press_ok_ff <= nxt_press_ok;
      pwrup_ff <= nxt_pwrup;
      ssi_skew_ff <= nxt_ssi_skew;
      skew_ff <= nxt_skew;
      both_d_ff <= nxt_both_d;
      pair_bad_ff <= nxt_pair_bad;
      sec_ms_ff <= nxt_sec_ms;
      secs_ff <= nxt_secs;
      open_seen_ff <= nxt_open_seen;
      ctrl_ff <= nxt_ctrl;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff <= nxt_irq;
      prdata_ff <= nxt_prdata;
      err_ff <= nxt_err;
      ssout_ff <= nxt_ssout;
      green_ff <= nxt_green;
      yellow_ff <= nxt_yellow;
      red_ff <= nxt_red;
      mute_ff <= nxt_mute;
      dash_ff <= nxt_dash;
      tens_ff <= nxt_tens;
      ones_ff <= nxt_ones;
      pled_ff <= psi_s;
      sled_ff <= ssi_s;
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = err_ff && psel && penable;
  assign irq = irq_ff;
  assign safety_switching_output = ssout_ff;
  assign green_led = green_ff;
  assign yellow_led = yellow_ff;
  assign red_led = red_ff;
  assign mute_lamp = mute_ff;
  assign primary_chan_led = pled_ff;
  assign supplemental_chan_led = sled_ff;
  assign disp_dash = dash_ff;
  assign disp_tens = tens_ff;
  assign disp_ones = ones_ff;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_release_ok;
    (hold_ff >= RST_MIN_TICKS) && (hold_ff <= RST_MAX_TICKS) && press_ok_ff;
  endsequence
  sequence s_bypass_tick;
    bypass && timed && sec_tick && (secs_ff != 6'h00);
  endsequence

  property p_reset_window;
    (state_ff == ST_WAIT) && (nxt_state == ST_RUN) && (cfg_manual || pwrup_ff) |-> s_release_ok;
  endproperty
  a_reset_window: assert property (p_reset_window) else $error("reset accepted outside window");
  property p_yellow;
    (state_ff == ST_WAIT) && cfg_manual |-> yellow_ff == flash_ff;
  endproperty
  a_yellow: assert property (p_yellow) else $error("yellow not flashing while awaiting reset");
  property p_lockout;
    state_ff == ST_LOCKOUT |-> (ssout_ff == 2'b00) && (red_ff == flash_ff) && !green_ff;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout outputs wrong");
  property p_psi_stop;
    (state_ff == ST_RUN) && !psi_clear |=> (ssout_ff == 2'b00) && !green_ff && (pled_ff != 2'b11);
  endproperty
  a_psi_stop: assert property (p_psi_stop) else $error("unmuted primary stop kept outputs");
  property p_ssi_stop;
    ((state_ff == ST_RUN) || (state_ff == ST_MUTE)) && !ssi_clear |=> (ssout_ff == 2'b00) && !green_ff;
  endproperty
  a_ssi_stop: assert property (p_ssi_stop) else $error("supplemental stop kept outputs");
  property p_reset_clear;
    rsw_s && !rsw_d_ff && !guards_clear ##1 rsw_s [*1] ##1 !rsw_s |-> state_ff != ST_RUN || $past(state_ff) == ST_RUN;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset before clear took effect");
  property p_wait_off;
    state_ff == ST_WAIT |-> ssout_ff == 2'b00;
  endproperty
  a_wait_off: assert property (p_wait_off) else $error("outputs on while latched");
  property p_skew;
    (state_ff == ST_RUN) && (nxt_state == ST_MUTE) |-> (|(pair_start & ~pair_bad_ff));
  endproperty
  a_skew: assert property (p_skew) else $error("mute without valid pair skew");
  property p_permit;
    (state_ff != ST_MUTE) && (nxt_state == ST_MUTE) |-> (permit_s || !cfg_permit) ##1 mute_lamp;
  endproperty
  a_permit: assert property (p_permit) else $error("mute entered without permit or lamp");
  property p_muted_hold;
    (state_ff == ST_MUTE) && any_sensor && ssi_clear && !bd_expire && !ssi_fault |=> ssout_ff == 2'b11 && green_ff;
  endproperty
  a_muted_hold: assert property (p_muted_hold) else $error("muted stop dropped outputs");
  property p_countdown;
    s_bypass_tick |=> secs_ff == $past(secs_ff) - 6'h01;
  endproperty
  a_countdown: assert property (p_countdown) else $error("backdoor count did not fall");
  property p_dash;
    (state_ff == ST_MUTE) && !psi_clear && !timed ##1 (state_ff == ST_MUTE) && !psi_clear |-> dash_ff == flash_ff;
  endproperty
  a_dash: assert property (p_dash) else $error("dash not shown without timer");
  property p_mute_end;
    (state_ff == ST_MUTE) && !any_sensor && guards_clear && !bd_expire |=> (state_ff == ST_RUN) && !mute_lamp && green_ff;
  endproperty
  a_mute_end: assert property (p_mute_end) else $error("mute end wrong");
  property p_one_way;
    cfg_one_way && (state_ff == ST_RUN) && (pa[1] || pb[1]) |=> state_ff != ST_MUTE;
  endproperty
  a_one_way: assert property (p_one_way) else $error("one-way mute accepted out of order");
  property p_expire;
    (state_ff == ST_MUTE) && bd_expire && !ssi_fault |=> (state_ff == ST_WAIT) && (ssout_ff == 2'b00);
  endproperty
  a_expire: assert property (p_expire) else $error("backdoor expiry ignored");
  property p_ssi_lock;
    ssi_fault && (state_ff != ST_LOCKOUT) |=> state_ff == ST_LOCKOUT;
  endproperty
  a_ssi_lock: assert property (p_ssi_lock) else $error("channel skew did not lock out");
endmodule
`default_nettype wire

/* File: tb/field_sim.sv */
`timescale 1ns/1ps
`default_nettype none
module field_sim (
  input wire logic pclk,
  output logic [1:0] primary_safeguard_input,
  output logic [1:0] supplemental_stop_input,
  output logic reset_switch,
  output logic [3:0] sen,
  output logic mute_permit_input
);
  // ==========================================================================
  // Guards clear, sensors idle, permit closed
  initial begin
    primary_safeguard_input = 2'h3;
    supplemental_stop_input = 2'h3;
    reset_switch = 1'b0;
    sen = 4'h0;
    mute_permit_input = 1'b1;
  end

  // Switch closed for clks cycles, then opened
  task automatic press(input int clks);
    @(posedge pclk) reset_switch <= 1'b1;
    repeat (clks) @(posedge pclk);
    reset_switch <= 1'b0;
  endtask

  // Pair idx active, sensor b gap cycles after sensor a
  task automatic pair(input int idx, input int gap);
    @(posedge pclk) sen[2*idx] <= 1'b1;
    repeat (gap) @(posedge pclk);
    sen[2*idx+1] <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: tb/safety_muting_controller_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module safety_muting_controller_tb;
  import safety_pkg::*;
  // ==========================================================================
  // Signals
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, look = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, green_led, yellow_led, red_led, mute_lamp, reset_switch;
  logic mute_permit_input, disp_dash;
  logic [1:0] primary_safeguard_input, supplemental_stop_input, safety_switching_output;
  logic [1:0] primary_chan_led, supplemental_chan_led;
  logic [3:0] sen, disp_tens, disp_ones;
  logic [32:0] q[$];
  int err_count = 0;
  int n_compared = 0;
  wire [16:0] pins = {disp_tens, disp_ones, irq, mute_lamp, green_led, safety_switching_output,
    primary_chan_led, supplemental_chan_led};
  wire [2:0] fl = {disp_dash, red_led, yellow_led};
  always #20 pclk = ~pclk;

  // ==========================================================================
  // Instances
  safety_muting_controller #(.TICK_CYCLES_P(4)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .primary_safeguard_input, .supplemental_stop_input, .reset_switch, .mute_permit_input,
    .first_pair_sensor_a(sen[0]), .first_pair_sensor_b(sen[1]),
    .second_pair_sensor_a(sen[2]), .second_pair_sensor_b(sen[3]),
    .safety_switching_output, .green_led, .yellow_led, .red_led, .mute_lamp, .primary_chan_led,
    .supplemental_chan_led, .disp_dash, .disp_tens, .disp_ones);
  field_sim fd (.pclk, .primary_safeguard_input, .supplemental_stop_input, .reset_switch, .sen,
    .mute_permit_input);

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pk(input logic [16:0] e);
    q.push_back({16'h0, e});
    look <= 1'b1;
    @(posedge pclk) look <= 1'b0;
  endtask
  task automatic flash(input int i);
    logic [1:0] seen;
    seen = 2'h0;
    repeat (2200) begin
      @(posedge pclk);
      seen = seen | {fl[i], ~fl[i]};
    end
    chk({31'h0, seen}, 33'h3);
  endtask
  task automatic accept();
    fd.press(1100 + $urandom_range(0, 2000));
    wt(8);
  endtask
  task automatic stop(input int s, input logic [16:0] e);
    if (s == 0) fd.primary_safeguard_input <= 2'h0;
    else fd.supplemental_stop_input <= 2'h0;
    wt(8);
    pk(e);
    fd.press(2000);
    wt(8);
    rd(ADDR_STATUS, {18'h0, BD_SHORT_S, 8'h00});
    fd.primary_safeguard_input <= 2'h3;
    fd.supplemental_stop_input <= 2'h3;
    wt(8);
    accept();
    pk(17'h0007f);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================================
  // Result watcher
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, q.pop_front());
    if (look) chk({16'h0, pins}, q.pop_front());
  end

  initial begin
    wt(100000);
    err_count++;
    tally_and_finish();
  end

  // ==========================================================================
  // Sequence
  initial begin
    void'($urandom(96));
    wt(4);
    presetn <= 1'b1;
    rd(ADDR_CTRL, 32'h01);
    rd(ADDR_IRQ_MASK, 32'h0);
    rd(ADDR_STATUS, {18'h0, BD_SHORT_S, 8'h80});
    rd(8'h10, 33'h100000000);
    flash(0);
    fd.press(600);
    wt(8);
    rd(ADDR_STATUS, {18'h0, BD_SHORT_S, 8'h80});
    fd.press(9000);
    wt(8);
    rd(ADDR_STATUS, {18'h0, BD_SHORT_S, 8'h80});
    accept();
    rd(ADDR_STATUS, {18'h0, BD_SHORT_S, 8'h1d});
    $display("test reset done");
    stop(0, 17'h00003);
    stop(1, 17'h0000c);
    $display("test stops done");
    apb(1'b1, ADDR_CTRL, 32'h0d);
    apb(1'b1, ADDR_IRQ_MASK, 32'h04);
    fd.pair(0, $urandom_range(1, 400));
    wt(8);
    pk(17'h001ff);
    fd.primary_safeguard_input <= 2'h0;
    wt(8);
    pk(17'h061f3);
    rd(ADDR_STATUS, 32'h1e7e);
    fd.primary_safeguard_input <= 2'h3;
    wt(8);
    fd.sen <= 4'h0;
    wt(8);
    pk(17'h0017f);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1f);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    pk(17'h0007f);
    apb(1'b1, ADDR_CTRL, 32'h05);
    fd.pair(1, 10);
    wt(8);
    fd.primary_safeguard_input <= 2'h0;
    flash(2);
    fd.primary_safeguard_input <= 2'h3;
    wt(8);
    fd.sen <= 4'h0;
    wt(8);
    $display("test mute done");
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, ADDR_CTRL, k == 1 ? 32'h07 : 32'h05);
      fd.mute_permit_input <= (k != 2);
      if (k == 1) fd.pair(1, 10);
      fd.pair(0, k == 0 ? 12400 : 10);
      wt(8);
      rd(ADDR_STATUS, {18'h0, BD_SHORT_S, 8'h1d});
      fd.sen <= 4'h0;
      wt(8);
    end
    fd.mute_permit_input <= 1'b1;
    $display("test refusals done");
    fd.supplemental_stop_input <= 2'h1;
    wt(12400);
    pk(17'h0000d);
    rd(ADDR_STATUS, {18'h0, BD_SHORT_S, 8'h03});
    flash(1);
    fd.supplemental_stop_input <= 2'h0;
    wt(8);
    fd.supplemental_stop_input <= 2'h3;
    wt(8);
    accept();
    presetn <= 1'b0;
    wt(2);
    pk(17'h0);
    presetn <= 1'b1;
    wt(8);
    pk(17'h0000f);
    rd(ADDR_STATUS, {18'h0, BD_SHORT_S, 8'h80});
    $display("test lockout and power done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
